//--- verilog/imu_cfg_map.svh
// Purpose: Offsets, field positions, reset values and timing figures of the config bank
// Assumes: 7-bit register locations carried in bits 14:8 of a command word
// Notes:   Definitions only
`ifndef IMU_CFG_MAP_SVH
`define IMU_CFG_MAP_SVH
// Byte write locations and word read locations
`define LOC_DRDY        7'h34
`define LOC_SELFTEST    7'h35
`define LOC_CLK_SEL     7'h36
`define LOC_RATE        7'h37
`define LOC_LPF         7'h38
`define LOC_RANGE       7'h39
`define LOC_DIAG        7'h3C
`define LOC_MAG_ALIGN   7'h50
// Reset values of the 16-bit words
`define RST_ST_DRDY     16'h0004
`define RST_RATE_CLK    16'h0101
`define RST_RANGE_LPF   16'h0206
`define RST_DIAG        16'h0000
`define RST_MAG         16'h0000
// Field positions
`define BIT_CMD_WRITE   15
`define BIT_ST_TRIG     10
`define BIT_DRDY_EN     2
`define BIT_DRDY_POL    1
`define BIT_CLK_SEL     0
`define BIT_DIAG_FAIL   5
`define BIT_DIAG_OVR    4
`define DIAG_AXIS_LSB   10
// Gyro range codes and over-range limits in units of 0.1 deg/s
`define RANGE_62        4'h1
`define RANGE_125       4'h2
`define RANGE_250       4'h4
`define LIMIT_62        16'h0271
`define LIMIT_125       16'h04E2
`define LIMIT_250       16'h09C4
// Timing figures
`define SYS_CLK_MHZ     50
`define TICK_US         1000
`define ST_BIAS_US      100
`define DRDY_US         10
`endif

//--- verilog/imu_cfg_pkg.sv
// Purpose: Types shared by the config bank
// Assumes: Nothing beyond the map header
// Notes:   No constants here; numbers live in imu_cfg_map.svh
`default_nettype none
package imu_cfg_pkg;
    // One received SPI command word split into its fields
    typedef struct packed {
        logic       is_write; // Top bit set marks a byte write
        logic [6:0] loc;      // Register location
        logic [7:0] data;     // Data byte of a write
    } spi_cmd_type;

    // Per-axis self-test verdicts, accel Z,Y,X then gyro Z,Y,X
    typedef struct packed {
        logic [5:0] axis_fail; // 1 means that axis failed
        logic       any_fail;  // Overall verdict
    } st_result_type;

    // Self-test sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BIAS,
        ST_JUDGE
    } st_state_type;
endpackage
`default_nettype wire

//--- verilog/imu_spi_config_regs.sv
// Purpose: SPI mode 3 configuration and diagnostic register bank of an IMU
// Assumes: One 16-bit word per chip-select frame; master idles spi_cs_n high between frames
// Notes:   Link logic runs on spi_sclk, registers on sys_clk; reads answer in the next frame
//
// Function
// - Diagnostic bits 15..10 hold per-axis fail flags
// - Diagnostic bit 5 holds overall self-test verdict
// - Diagnostic bit 4 flags any sensor over-range
// - Writes are byte wide, reads return words
// - Self-test byte 0x35, data-ready byte 0x34
// - Rate byte 0x37, clock select byte 0x36
// - Range 0x39, filter 0x38, mag align 0x50
// - Trigger bit stays set until test ends
// - Read of 0x34 returns both bytes together
// - Results land in diagnostic word on completion
// - Self-test biases sensors then judges each axis
// - Bit 2 enables data-ready, reset value 0x0004
// - Bit 1 picks data-ready polarity, low default
// - Rate code selects 200 Hz down to 1 Hz
// - Rate paces data-ready; code zero stops it
// - Bit 0 picks internal or external 1 kHz
// - Rate and clock affect SPI data and data-ready only
// - SPI mode 3, 16-bit words, MSB first
// - Over-range limit follows selected gyro range
`timescale 1ns/10ps
`default_nettype none
`include "imu_cfg_map.svh"
module imu_spi_config_regs #(
    parameter int MS_CYCLES   = `TICK_US * `SYS_CLK_MHZ,    // Cycles per 1 ms internal tick
    parameter int BIAS_CYCLES = `ST_BIAS_US * `SYS_CLK_MHZ, // Cycles the test bias is applied
    parameter int DRDY_CYCLES = `DRDY_US * `SYS_CLK_MHZ     // Width of a data-ready assertion
) (
    input  wire logic        sys_clk,          // System clock, 50 MHz
    input  wire logic        rst_n,            // Synchronous reset, active low
    input  wire logic        spi_sclk,         // SPI clock from the master, idles high
    input  wire logic        spi_cs_n,         // SPI chip select, active low
    input  wire logic        spi_mosi,         // SPI data from the master
    output logic             spi_miso,         // SPI data to the master
    output logic             spi_miso_oe,      // High while the bank drives spi_miso
    input  wire logic        ext_sync_1khz,    // External 1 kHz sync pin
    input  wire logic [5:0]  sensor_ok,        // Per-axis response good during bias
    input  wire logic        accel_over_range, // Accelerometer beyond its span
    input  wire logic [15:0] gyro_abs_rate,    // Largest gyro magnitude, 0.1 deg/s
    output logic             selftest_bias,    // Applies the test bias to the sensors
    output logic             data_ready,       // Data-ready pin level
    output logic             spi_sample_tick,  // One-cycle pulse per SPI output sample
    output logic [3:0]       gyro_range_byte,  // Selected gyro range code
    output logic [7:0]       lpf_byte,         // Selected low-pass filter code
    output logic             mag_align_start   // One-cycle pulse on a mag-align command
);
    // Elaboration check on the counts the counters can hold
    generate
        if (MS_CYCLES < 2 || MS_CYCLES > 65535 || BIAS_CYCLES < 1 || BIAS_CYCLES > 65535 ||
            DRDY_CYCLES < 1 || DRDY_CYCLES > 65535) begin : g_bad_param
            $error("imu_spi_config_regs: count parameter out of range");
        end
    endgenerate

    localparam logic [15:0] MS_LAST   = 16'(MS_CYCLES - 1);   // Last count of the ms tick
    localparam logic [15:0] BIAS_LAST = 16'(BIAS_CYCLES - 1); // Last count of the bias phase
    localparam logic [15:0] DRDY_LAST = 16'(DRDY_CYCLES - 1); // Last count of a drdy pulse

    // ---------------- Link domain (spi_sclk) ----------------
    logic        link_rst;   // Link reset, a sys_clk flop driving async clears
    logic [3:0]  in_count;   // Bits received in this frame
    logic [14:0] in_shift;   // Bits received so far
    logic [15:0] rx_word;    // Last complete word, held for the sys side
    logic        rx_toggle;  // Flips once per complete word
    logic [3:0]  out_count;  // Bits sent in this frame
    logic        miso_q;     // Registered output bit
    logic [15:0] reply_word; // Read answer, sys domain, stable during a frame

    // Link reset follows the system reset
    always_ff @(posedge sys_clk) begin
        link_rst <= ~rst_n;
    end

    // Sample MOSI on rising edges, MSB first, one word per frame
    always_ff @(posedge spi_sclk or posedge spi_cs_n or posedge link_rst) begin
        if (spi_cs_n || link_rst) begin
            in_count <= 4'h0;
            in_shift <= 15'h0000;
        end else begin
            in_count <= in_count + 4'h1;
            in_shift <= {in_shift[13:0], spi_mosi};
        end
    end

    // Capture the word on its 16th bit and flag it by a toggle
    always_ff @(posedge spi_sclk or posedge link_rst) begin
        if (link_rst) begin
            rx_word   <= 16'h0000;
            rx_toggle <= 1'b0;
        end else if (!spi_cs_n && in_count == 4'hF) begin
            rx_word   <= {in_shift, spi_mosi};
            rx_toggle <= ~rx_toggle;
        end
    end

    // Drive MISO on falling edges; first falling edge presents the MSB
    always_ff @(negedge spi_sclk or posedge spi_cs_n or posedge link_rst) begin
        if (spi_cs_n || link_rst) begin
            out_count <= 4'h0;
            miso_q    <= 1'b0;
        end else begin
            out_count <= out_count + 4'h1;
            miso_q    <= reply_word[4'hF - out_count];
        end
    end

    assign spi_miso    = miso_q;
    assign spi_miso_oe = ~spi_cs_n;

    // ---------------- System domain (sys_clk) ----------------
    logic [2:0]  rx_sync;   // Toggle synchroniser plus edge stage
    logic [2:0]  ext_sync;  // External sync synchroniser plus edge stage
    logic        cmd_valid; // One-cycle pulse for a new command word
    imu_cfg_pkg::spi_cmd_type cmd; // Decoded command

    // Bring the word toggle and the external sync pin across
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rx_sync  <= 3'h0;
            ext_sync <= 3'h0;
        end else begin
            rx_sync  <= {rx_sync[1:0], rx_toggle};
            ext_sync <= {ext_sync[1:0], ext_sync_1khz};
        end
    end

    assign cmd_valid    = rx_sync[2] ^ rx_sync[1];
    assign cmd.is_write = rx_word[`BIT_CMD_WRITE];
    assign cmd.loc      = rx_word[14:8];
    assign cmd.data     = rx_word[7:0];

    logic       write_hit; // Valid byte write
    logic       read_hit;  // Valid read request
    assign write_hit = cmd_valid && cmd.is_write;
    assign read_hit  = cmd_valid && !cmd.is_write;

    // Stored configuration fields; unused bits are not stored at all
    logic       st_trig;    // Self-test running
    logic       drdy_en;    // Data-ready enable
    logic       drdy_pol;   // Data-ready active high when set
    logic [3:0] sample_rate_code; // Output rate code
    logic       clk_sel;    // 1 internal, 0 external timing
    logic [7:0] mag_init;   // Last mag-align initiation byte
    imu_cfg_pkg::st_result_type st_res; // Latest self-test verdicts
    logic       over_range; // Sticky over-range flag
    logic       st_done;    // Pulse when the test finishes
    logic       st_start;   // Pulse when a test is requested

    assign st_start = write_hit && cmd.loc == `LOC_SELFTEST && cmd.data[`BIT_ST_TRIG - 8]
                      && !st_trig;

    // Data-ready byte of the word at 0x34; its self-test byte is in the next block
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            drdy_en  <= 1'(`RST_ST_DRDY >> `BIT_DRDY_EN);
            drdy_pol <= 1'(`RST_ST_DRDY >> `BIT_DRDY_POL);
        end else if (write_hit && cmd.loc == `LOC_DRDY) begin
            drdy_en  <= cmd.data[`BIT_DRDY_EN];
            drdy_pol <= cmd.data[`BIT_DRDY_POL];
        end
    end

    // Trigger bit: set by a write, held while the test runs, cleared at the end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_trig <= 1'(`RST_ST_DRDY >> `BIT_ST_TRIG);
        end else if (st_start) begin
            st_trig <= 1'b1;
        end else if (st_done) begin
            st_trig <= 1'b0;
        end
    end

    // Rate and clock-select bytes of the word at 0x36
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sample_rate_code <= 4'(`RST_RATE_CLK >> 8);
            clk_sel          <= 1'(`RST_RATE_CLK >> `BIT_CLK_SEL);
        end else if (write_hit && cmd.loc == `LOC_RATE) begin
            sample_rate_code <= cmd.data[3:0];
        end else if (write_hit && cmd.loc == `LOC_CLK_SEL) begin
            clk_sel          <= cmd.data[`BIT_CLK_SEL];
        end
    end

    // Range and filter bytes of the word at 0x38, and the mag-align command
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            gyro_range_byte <= 4'(`RST_RANGE_LPF >> 8);
            lpf_byte        <= 8'(`RST_RANGE_LPF);
            mag_init        <= 8'(`RST_MAG >> 8);
            mag_align_start <= 1'b0;
        end else begin
            mag_align_start <= write_hit && cmd.loc == `LOC_MAG_ALIGN;
            if (write_hit && cmd.loc == `LOC_RANGE) begin
                gyro_range_byte <= cmd.data[3:0];
            end
            if (write_hit && cmd.loc == `LOC_LPF) begin
                lpf_byte <= cmd.data;
            end
            if (write_hit && cmd.loc == `LOC_MAG_ALIGN) begin
                mag_init <= cmd.data;
            end
        end
    end

    // Self-test sequencer: bias the sensors, then judge each axis
    imu_cfg_pkg::st_state_type st_state; // Sequencer state
    logic [15:0] bias_count;              // Cycles spent under bias

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_state   <= imu_cfg_pkg::ST_IDLE;
            bias_count <= 16'h0000;
        end else begin
            case (st_state)
                imu_cfg_pkg::ST_IDLE: begin
                    bias_count <= 16'h0000;
                    if (st_start) begin
                        st_state <= imu_cfg_pkg::ST_BIAS;
                    end
                end
                imu_cfg_pkg::ST_BIAS: begin
                    bias_count <= bias_count + 16'h0001;
                    if (bias_count == BIAS_LAST) begin
                        st_state <= imu_cfg_pkg::ST_JUDGE;
                    end
                end
                imu_cfg_pkg::ST_JUDGE: begin
                    st_state <= imu_cfg_pkg::ST_IDLE;
                end
                default: begin
                    st_state <= imu_cfg_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign st_done       = st_state == imu_cfg_pkg::ST_JUDGE;
    assign selftest_bias = st_state == imu_cfg_pkg::ST_BIAS;

    // Record the verdicts when the test finishes
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_res <= '0;
        end else if (st_done) begin
            st_res.axis_fail <= ~sensor_ok;
            st_res.any_fail  <= ~&sensor_ok;
        end
    end

    // Over-range limit picked from the gyro range
    logic [15:0] range_limit; // Current limit in 0.1 deg/s
    always_comb begin
        case (gyro_range_byte)
            `RANGE_62:  range_limit = `LIMIT_62;
            `RANGE_125: range_limit = `LIMIT_125;
            `RANGE_250: range_limit = `LIMIT_250;
            default:    range_limit = `LIMIT_125;
        endcase
    end

    // Sticky over-range flag; a new event wins over the self-test clear
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            over_range <= 1'(`RST_DIAG >> `BIT_DIAG_OVR);
        end else if (accel_over_range || gyro_abs_rate > range_limit) begin
            over_range <= 1'b1;
        end else if (st_start) begin
            over_range <= 1'b0;
        end
    end

    // Read answer, taken up by the next frame
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reply_word <= 16'h0000;
        end else if (read_hit) begin
            case (cmd.loc)
                `LOC_DRDY: reply_word <= {5'h00, st_trig, 7'h00, drdy_en, drdy_pol,
                                          1'b0};
                `LOC_CLK_SEL: reply_word <= {4'h0, sample_rate_code, 7'h00, clk_sel};
                `LOC_LPF: reply_word <= {4'h0, gyro_range_byte, lpf_byte};
                `LOC_DIAG: reply_word <= {st_res.axis_fail, 4'h0, st_res.any_fail,
                                          over_range, 4'h0};
                `LOC_MAG_ALIGN: reply_word <= {mag_init, 8'h00};
                default: reply_word <= 16'h0000;
            endcase
        end
    end

    // Millisecond tick from the internal counter or the external sync edge
    logic [15:0] ms_count; // Internal 1 kHz divider
    logic        ms_tick;  // One pulse per millisecond
    always_ff @(posedge sys_clk) begin
        if (!rst_n || ms_count == MS_LAST) begin
            ms_count <= 16'h0000;
        end else begin
            ms_count <= ms_count + 16'h0001;
        end
    end

    assign ms_tick = clk_sel ? (ms_count == MS_LAST)
                             : (ext_sync[1] && !ext_sync[2]);

    // Milliseconds between samples for each rate code; zero means none
    function automatic logic [9:0] rate_period(input logic [3:0] code);
        case (code)
            4'h1:    rate_period = 10'h005; // 200 Hz
            4'h2:    rate_period = 10'h00A; // 100 Hz
            4'h3:    rate_period = 10'h014; // 50 Hz
            4'h4:    rate_period = 10'h028; // 25 Hz
            4'h5:    rate_period = 10'h032; // 20 Hz
            4'h6:    rate_period = 10'h064; // 10 Hz
            4'h7:    rate_period = 10'h0C8; // 5 Hz
            4'h8:    rate_period = 10'h0FA; // 4 Hz
            4'h9:    rate_period = 10'h1F4; // 2 Hz
            4'hA:    rate_period = 10'h3E8; // 1 Hz
            default: rate_period = 10'h000; // Output suppressed
        endcase
    endfunction

    logic [9:0] period;   // Current sample period in ms
    logic [9:0] rate_cnt; // Milliseconds since the last sample
    assign period = rate_period(sample_rate_code);

    // Sample pacing; both the SPI output path and the data-ready pulse see this tick
    always_ff @(posedge sys_clk) begin
        if (!rst_n || period == 10'h000) begin
            rate_cnt        <= 10'h000;
            spi_sample_tick <= 1'b0;
        end else if (ms_tick) begin
            spi_sample_tick <= rate_cnt >= period - 10'h001;
            rate_cnt <= (rate_cnt >= period - 10'h001) ? 10'h000 : rate_cnt + 10'h001;
        end else begin
            spi_sample_tick <= 1'b0;
        end
    end

    // Data-ready pulse stretched to its width, then set to the chosen polarity
    logic [15:0] drdy_count;  // Cycles left in the assertion
    logic        drdy_active; // Data-ready asserted
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            drdy_count  <= 16'h0000;
            drdy_active <= 1'b0;
        end else if (spi_sample_tick) begin
            drdy_count  <= DRDY_LAST;
            drdy_active <= 1'b1;
        end else if (drdy_count != 16'h0000) begin
            drdy_count  <= drdy_count - 16'h0001;
        end else begin
            drdy_active <= 1'b0;
        end
    end

    // Pin level; disabled means the inactive level of the chosen polarity
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            data_ready <= 1'b1;
        end else begin
            data_ready <= (drdy_en && drdy_active) ? drdy_pol : ~drdy_pol;
        end
    end
endmodule
`default_nettype wire

//--- sim/imu_spi_config_regs_props.sv
// Purpose: Port-level checks of the config bank
// Assumes: Parameters match the bound instance
// Notes:   Sys-clock domain only; link pins are sampled there too
`timescale 1ns/10ps
`default_nettype none
module imu_spi_config_regs_props #(
    parameter int MS_CYCLES   = 50000, // Cycles per 1 ms tick
    parameter int BIAS_CYCLES = 5000,  // Cycles of test bias
    parameter int DRDY_CYCLES = 500    // Data-ready pulse width
) (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       spi_cs_n,
    input wire logic       spi_miso,
    input wire logic       spi_miso_oe,
    input wire logic       selftest_bias,
    input wire logic       data_ready,
    input wire logic       spi_sample_tick,
    input wire logic [3:0] gyro_range_byte,
    input wire logic [7:0] lpf_byte,
    input wire logic       mag_align_start
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    int bias_cnt; // Cycles the bias has been high
    // Count the length of each bias phase
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bias_cnt <= 0;
        end else begin
            bias_cnt <= selftest_bias ? bias_cnt + 1 : 0;
        end
    end
    // Steps of a self-test and of a data-ready edge
    sequence s_bias_start; $rose(selftest_bias); endsequence
    sequence s_drdy_edge; !$stable(data_ready); endsequence
    property p_oe; spi_miso_oe == !spi_cs_n; endproperty
    property p_miso_idle; spi_cs_n |-> !spi_miso; endproperty
    property p_bias_hold; s_bias_start |-> selftest_bias [*8]; endproperty
    property p_bias_len; $fell(selftest_bias) |-> bias_cnt == BIAS_CYCLES; endproperty
    property p_tick; spi_sample_tick |=> !spi_sample_tick; endproperty
    property p_mag; mag_align_start |=> !mag_align_start; endproperty
    property p_cfg_idle; ($changed(gyro_range_byte) || $changed(lpf_byte)) |-> spi_cs_n;
    endproperty
    property p_rst_vals;
        $rose(rst_n) |-> data_ready && !selftest_bias && gyro_range_byte == 4'h2
            && lpf_byte == 8'h06;
    endproperty
    property p_drdy; s_drdy_edge |=> $stable(data_ready) [*3]; endproperty
    a_oe: assert property (p_oe) else $error("miso enable off");
    a_miso_idle: assert property (p_miso_idle) else $error("miso not idle");
    a_bias_hold: assert property (p_bias_hold) else $error("bias short");
    a_bias_len: assert property (p_bias_len) else $error("bias length");
    a_tick: assert property (p_tick) else $error("tick too long");
    a_mag: assert property (p_mag) else $error("mag pulse too long");
    a_cfg_idle: assert property (p_cfg_idle) else $error("config moved in frame");
    a_rst_vals: assert property (p_rst_vals) else $error("bad reset outputs");
    a_drdy: assert property (p_drdy) else $error("data-ready glitch");
endmodule
bind imu_spi_config_regs imu_spi_config_regs_props #(
    .MS_CYCLES(MS_CYCLES), .BIAS_CYCLES(BIAS_CYCLES), .DRDY_CYCLES(DRDY_CYCLES)
) u_imu_spi_config_regs_props (
    .sys_clk(sys_clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .selftest_bias(selftest_bias), .data_ready(data_ready),
    .spi_sample_tick(spi_sample_tick), .gyro_range_byte(gyro_range_byte),
    .lpf_byte(lpf_byte), .mag_align_start(mag_align_start)
);
`default_nettype wire

//--- sim/spi_master_model.sv
// Purpose: Mode 3 SPI master standing in for the host
// Assumes: 48 ns bit clock, parked high outside frames
// Notes:   xfer sends one word and returns the bits seen on miso
`timescale 1ns/10ps
`default_nettype none
module spi_master_model (
    output logic      spi_sclk, // Bit clock, idles high
    output logic      spi_cs_n, // Frame select
    output logic      spi_mosi, // Data to the bank
    input  wire logic spi_miso  // Data from the bank
);
    // Idle bus at start
    initial begin
        spi_sclk = 1'b1;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // One 16-bit frame, MSB first, change on fall, take on rise
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        spi_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            #24 spi_sclk = 1'b0;
            spi_mosi = w[i];
            #24 spi_sclk = 1'b1;
            r[i] = spi_miso;
        end
        #24 spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi; // Released line shows no stale bit
        #400;                 // Gap so the reply word settles
    endtask
endmodule
`default_nettype wire

//--- sim/imu_spi_config_regs_test.sv
// Purpose: Self-checking bench for the config bank over its SPI link
// Assumes: Short tick, bias and pulse counts for a quick run
// Notes:   External sync runs at 60 cycles so it differs from the tick
`timescale 1ns/10ps
`default_nettype none
module imu_spi_config_regs_test;
    localparam int MS = 50;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        spi_sclk;
    logic        spi_cs_n;
    logic        spi_mosi;
    logic        spi_miso;
    logic        ext_sync_1khz = 1'b0;
    logic [5:0]  sensor_ok = 6'h2D;
    logic        accel_over_range = 1'b0;
    logic [15:0] gyro_abs_rate = 16'h0000;
    logic        selftest_bias;
    logic        data_ready;
    logic        spi_sample_tick;
    logic [3:0]  gyro_range_byte;
    logic [7:0]  lpf_byte;
    logic        mag_align_start;
    logic        mag_seen = 1'b0;
    int          sync_cnt = 0;
    int          err_count = 0;
    int          n_compared = 0;
    int          ms_tab [1:6] = '{5, 10, 20, 40, 50, 100};
    logic [6:0]  rloc [5] = '{7'h34, 7'h36, 7'h38, 7'h3C, 7'h40};
    logic [15:0] rval [5] = '{16'h0004, 16'h0101, 16'h0206, 16'h0000, 16'h0000};
    always #10 sys_clk = ~sys_clk;
    // Sync pin and mag-align pulse watch
    always @(posedge sys_clk) begin
        sync_cnt <= (sync_cnt == 59) ? 0 : sync_cnt + 1;
        ext_sync_1khz <= (sync_cnt < 30);
        if (mag_align_start === 1'b1) mag_seen <= 1'b1;
    end
    imu_spi_config_regs #(.MS_CYCLES(MS), .BIAS_CYCLES(100), .DRDY_CYCLES(4))
    u_imu_spi_config_regs (
        .sys_clk(sys_clk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(), .ext_sync_1khz(ext_sync_1khz),
        .sensor_ok(sensor_ok), .accel_over_range(accel_over_range),
        .gyro_abs_rate(gyro_abs_rate), .selftest_bias(selftest_bias), .data_ready(data_ready),
        .spi_sample_tick(spi_sample_tick), .gyro_range_byte(gyro_range_byte),
        .lpf_byte(lpf_byte), .mag_align_start(mag_align_start)
    );
    spi_master_model u_spi_master_model (
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso)
    );
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] c);
        logic [15:0] r;
        u_spi_master_model.xfer(c, r);
    endtask
    // Read answers in the following frame
    task automatic rd(input logic [6:0] loc, input logic [15:0] exp);
        logic [15:0] r;
        u_spi_master_model.xfer({1'b0, loc, 8'h00}, r);
        u_spi_master_model.xfer(16'h0000, r);
        chk(r, exp);
    endtask
    // Cycles between two sample ticks
    task automatic period(input int exp);
        int n;
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            for (n = 1; n < 60000 && spi_sample_tick !== 1'b1; n++) @(posedge sys_clk);
        end
        chk(n[15:0], exp[15:0]);
    endtask
    // Whether tick or data-ready shows a level within 600 cycles
    task automatic seen(input logic sel, input logic lvl, input logic exp);
        logic f;
        f = 1'b0;
        repeat (600) begin
            @(posedge sys_clk);
            f |= ((sel ? spi_sample_tick : data_ready) === lvl);
        end
        chk({15'h0000, f}, {15'h0000, exp});
    endtask
    // One-cycle over-range event: accel or gyro at 0x0300
    task automatic bump(input logic acc);
        @(posedge sys_clk);
        accel_over_range <= acc;
        gyro_abs_rate <= acc ? 16'h0000 : 16'h0300;
        @(posedge sys_clk);
        accel_over_range <= 1'b0;
        gyro_abs_rate <= 16'h0000;
    endtask
    task automatic end_sim;
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        wr(16'hBAFF);
        for (int i = 0; i < 5; i++) rd(rloc[i], rval[i]);
        wr(16'hB406);
        rd(7'h34, 16'h0006);
        seen(1'b0, 1'b1, 1'b1);
        wr(16'hB402);
        seen(1'b0, 1'b1, 1'b0);
        wr(16'hB404);
        seen(1'b0, 1'b0, 1'b1);
        wr(16'hB7FA);
        rd(7'h36, 16'h0A01);
        for (int c = 1; c <= 6; c++) begin
            wr({8'hB7, c[7:0]});
            period(ms_tab[c] * MS);
        end
        wr(16'hB701);
        wr(16'hB600);
        rd(7'h36, 16'h0100);
        period(300);
        wr(16'hB601);
        wr(16'hB700);
        seen(1'b1, 1'b1, 1'b0);
        bump(1'b0);
        rd(7'h3C, 16'h0000);
        wr(16'hB901);
        wr(16'hB840);
        rd(7'h38, 16'h0140);
        chk({4'h0, gyro_range_byte, lpf_byte}, 16'h0140);
        bump(1'b0);
        rd(7'h3C, 16'h0010);
        wr(16'hB504);
        rd(7'h34, 16'h0404);
        rd(7'h34, 16'h0004);
        rd(7'h3C, 16'h4820);
        bump(1'b1);
        rd(7'h3C, 16'h4830);
        @(posedge sys_clk) sensor_ok <= 6'h3F;
        wr(16'hB504);
        rd(7'h34, 16'h0404);
        rd(7'h3C, 16'h0000);
        wr(16'hD001);
        chk({15'h0000, mag_seen}, 16'h0001);
        rd(7'h50, 16'h0100);
        end_sim();
    end
    // Hang guard
    initial begin
        repeat (80000) @(posedge sys_clk);
        err_count++;
        end_sim();
    end
endmodule
`default_nettype wire
